/* File: hw/csb_pkg.sv */
// package: encodings, structs and timing for compare/skip/branch execution
package csb_pkg;
    localparam int unsigned CSB_DATA_W  = 8;
    localparam int unsigned CSB_PC_W    = 16;
    localparam int unsigned CSB_OFF_W   = 7;
    localparam int unsigned CSB_BIT_W   = 3;
    localparam int unsigned CSB_IO_W    = 6;
    localparam int unsigned CSB_REG_W   = 5;
    // status flag positions
    localparam int unsigned CSB_FLG_C   = 0;
    localparam int unsigned CSB_FLG_Z   = 1;
    localparam int unsigned CSB_FLG_N   = 2;
    localparam int unsigned CSB_FLG_V   = 3;
    localparam int unsigned CSB_FLG_S   = 4;
    localparam int unsigned CSB_FLG_H   = 5;
    localparam logic [7:0]  CSB_FLAGS_RST = 8'h00;
    localparam logic [15:0] CSB_PC_RST    = 16'h0000;
    // cycle counts
    localparam logic [1:0]  CSB_CYC_ONE   = 2'h1;
    localparam logic [1:0]  CSB_CYC_TWO   = 2'h2;
    localparam logic [1:0]  CSB_CYC_THREE = 2'h3;
    localparam logic [15:0] CSB_PC_STEP   = 16'h0001;

    typedef enum logic [2:0]
    {
        CSB_OP_NONE            = 3'h0,
        CSB_OP_COMPARE_IMM     = 3'h1,
        CSB_OP_SKIP_REG_CLEAR  = 3'h2,
        CSB_OP_SKIP_REG_SET    = 3'h3,
        CSB_OP_SKIP_IO_CLEAR   = 3'h4,
        CSB_OP_SKIP_IO_SET     = 3'h5,
        CSB_OP_BRANCH_SET      = 3'h6,
        CSB_OP_BRANCH_CLEAR    = 3'h7
    } csb_op_t;

    typedef struct packed
    {
        csb_op_t                op;
        logic [CSB_REG_W-1:0]   reg_sel;
        logic [CSB_IO_W-1:0]    io_sel;
        logic [CSB_BIT_W-1:0]   bit_sel;
        logic [CSB_DATA_W-1:0]  imm;
        logic [CSB_OFF_W-1:0]   offset;
        logic                   next_two_word;
    } csb_instr_t;

    typedef enum logic [2:0]
    {
        CSB_ST_EXEC   = 3'b001,
        CSB_ST_SKIP1  = 3'b010,
        CSB_ST_SKIP2  = 3'b100
    } csb_state_t;
endpackage

/* File: hw/csb_flag_alu.sv */
// compare subtractor producing the status flags
`timescale 1ns/1ns
`default_nettype none
module csb_flag_alu
    import csb_pkg::*;
(
    input  wire logic [CSB_DATA_W-1:0] i_a,
    input  wire logic [CSB_DATA_W-1:0] i_b,
    input  wire logic [7:0]            i_flags,
    output logic      [7:0]            o_flags
);
    wire logic [CSB_DATA_W-1:0] diff = i_a - i_b;
    wire logic neg  = diff[7];
    wire logic ovf  = (i_a[7] & ~i_b[7] & ~diff[7]) | (~i_a[7] & i_b[7] & diff[7]);
    wire logic cry  = (~i_a[7] & i_b[7]) | (i_b[7] & diff[7]) | (diff[7] & ~i_a[7]);
    wire logic half = (~i_a[3] & i_b[3]) | (i_b[3] & diff[3]) | (diff[3] & ~i_a[3]);

    always_comb
    begin
        o_flags            = i_flags;
        o_flags[CSB_FLG_C] = cry;
        o_flags[CSB_FLG_Z] = (diff == 8'h00);
        o_flags[CSB_FLG_N] = neg;
        o_flags[CSB_FLG_V] = ovf;
        o_flags[CSB_FLG_S] = neg ^ ovf;
        o_flags[CSB_FLG_H] = half;
    end
endmodule
`default_nettype wire

/* File: hw/csb_exec.sv */
// execution unit for compare-immediate, bit skips and flag branches
// Contract
// - compare immediate subtracts constant, sets Z N V S C H, one cycle, no store
// - skip next instruction when chosen register bit is zero; flags kept
// - skip next instruction when chosen register bit is one; flags kept
// - skip next instruction when chosen I/O bit reads zero; flags kept
// - skip next instruction when chosen I/O bit reads one; flags kept
// - branch to pc plus offset plus one when chosen flag is set
// - branch to pc plus offset plus one when chosen flag is clear
`timescale 1ns/1ns
`default_nettype none
module csb_exec
    import csb_pkg::*;
(
    input  wire logic                  i_clock,
    input  wire logic                  i_nrst,
    input  wire logic                  i_valid,
    input  wire csb_instr_t            i_instr,
    input  wire logic [CSB_DATA_W-1:0] i_reg_data,
    input  wire logic [CSB_DATA_W-1:0] i_io_data,
    output logic                       o_ready,
    output logic                       o_done,
    output logic [CSB_PC_W-1:0]        o_pc,
    output logic [7:0]                 o_flags,
    output logic                       o_skipping
);
    csb_state_t              state_r;
    csb_state_t              state_nxt;
    logic [CSB_PC_W-1:0]     pc_r;
    logic [CSB_PC_W-1:0]     pc_nxt;
    logic [7:0]              flags_r;
    logic [7:0]              flags_nxt;
    logic                    done_r;
    logic                    done_nxt;
    logic [7:0]              cmp_flags;

    function automatic logic pick_bit(input logic [7:0] v, input logic [2:0] sel);
        pick_bit = v[sel];
    endfunction

    csb_flag_alu u_alu
    (
        .i_a     (i_reg_data),
        .i_b     (i_instr.imm),
        .i_flags (flags_r),
        .o_flags (cmp_flags)
    );

    wire logic exec_go  = i_valid && (state_r == CSB_ST_EXEC);
    wire logic reg_bit  = pick_bit(i_reg_data, i_instr.bit_sel);
    wire logic io_bit   = pick_bit(i_io_data, i_instr.bit_sel);
    wire logic flag_bit = pick_bit(flags_r, i_instr.bit_sel);
    wire logic skip_hit =
        (i_instr.op == CSB_OP_SKIP_REG_CLEAR && !reg_bit) ||
        (i_instr.op == CSB_OP_SKIP_REG_SET   &&  reg_bit) ||
        (i_instr.op == CSB_OP_SKIP_IO_CLEAR  && !io_bit)  ||
        (i_instr.op == CSB_OP_SKIP_IO_SET    &&  io_bit);
    wire logic br_hit =
        (i_instr.op == CSB_OP_BRANCH_SET   &&  flag_bit) ||
        (i_instr.op == CSB_OP_BRANCH_CLEAR && !flag_bit);
    // sign-extended offset, plus the ordinary one-word step
    wire logic [CSB_PC_W-1:0] br_target =
        pc_r + {{(CSB_PC_W-CSB_OFF_W){i_instr.offset[CSB_OFF_W-1]}}, i_instr.offset}
             + CSB_PC_STEP;

    always_comb
    begin
        state_nxt = state_r;
        pc_nxt    = pc_r;
        flags_nxt = flags_r;
        done_nxt  = 1'b0;
        case (state_r)
            CSB_ST_EXEC:
            begin
                if (exec_go)
                begin
                    pc_nxt = pc_r + CSB_PC_STEP;
                    if (i_instr.op == CSB_OP_COMPARE_IMM)
                    begin
                        flags_nxt = cmp_flags;
                        done_nxt  = 1'b1;
                    end
                    else if (br_hit)
                    begin
                        pc_nxt   = br_target;
                        done_nxt = 1'b1;
                    end
                    else if (skip_hit)
                    begin
                        // hop one word per extra cycle
                        state_nxt = i_instr.next_two_word ? CSB_ST_SKIP2 : CSB_ST_SKIP1;
                    end
                    else
                    begin
                        done_nxt = 1'b1;
                    end
                end
            end
            CSB_ST_SKIP2:
            begin
                pc_nxt    = pc_r + CSB_PC_STEP;
                state_nxt = CSB_ST_SKIP1;
            end
            CSB_ST_SKIP1:
            begin
                pc_nxt    = pc_r + CSB_PC_STEP;
                state_nxt = CSB_ST_EXEC;
                done_nxt  = 1'b1;
            end
            default:
            begin
                state_nxt = CSB_ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_r <= CSB_ST_EXEC;
            pc_r    <= CSB_PC_RST;
            flags_r <= CSB_FLAGS_RST;
            done_r  <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            pc_r    <= pc_nxt;
            flags_r <= flags_nxt;
            done_r  <= done_nxt;
        end
    end

    // outputs registered; ready derived from next state to stay a flop
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_ready    <= 1'b0;
            o_skipping <= 1'b0;
        end
        else
        begin
            o_ready    <= (state_nxt == CSB_ST_EXEC);
            o_skipping <= (state_nxt != CSB_ST_EXEC);
        end
    end

    assign o_done  = done_r;
    assign o_pc    = pc_r;
    assign o_flags = flags_r;
endmodule
`default_nettype wire

/* File: sim/csb_exec_assertions.sv */
// assertion checker for the compare/skip/branch execution unit
`timescale 1ns/1ns
`default_nettype none
module csb_exec_assertions
    import csb_pkg::*;
(
    input  wire logic                  i_clock,
    input  wire logic                  i_nrst,
    input  wire logic                  i_valid,
    input  wire csb_instr_t            i_instr,
    input  wire logic [CSB_DATA_W-1:0] i_reg_data,
    input  wire logic [CSB_DATA_W-1:0] i_io_data,
    input  wire logic                  o_ready,
    input  wire logic                  o_done,
    input  wire logic [CSB_PC_W-1:0]   o_pc,
    input  wire logic [7:0]            o_flags,
    input  wire logic                  o_skipping
);
    wire logic        tk  = i_valid && o_ready;
    wire csb_op_t     op  = i_instr.op;
    wire logic        rb  = i_reg_data[i_instr.bit_sel];
    wire logic        ib  = i_io_data[i_instr.bit_sel];
    wire logic        fb  = o_flags[i_instr.bit_sel];
    // skip hit: odd codes test for one, even codes for zero
    wire logic        sk  = tk && op[2:1] inside {2'h1, 2'h2} && (op[1] ? rb : ib) == op[0];
    wire logic [15:0] tgt = o_pc + {{9{i_instr.offset[6]}}, i_instr.offset} + 16'h0001;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    chk_cmp_one_cycle: assert property (tk && op == CSB_OP_COMPARE_IMM
        |=> o_done && o_pc == $past(o_pc) + 16'h0001) else $error("compare late");
    chk_skip_reg_clr: assert property (tk && op == CSB_OP_SKIP_REG_CLEAR && !rb
        |=> o_skipping && !o_ready && $stable(o_flags)) else $error("reg clear skip");
    chk_skip_reg_set: assert property (tk && op == CSB_OP_SKIP_REG_SET && rb
        |=> o_skipping && !o_ready && $stable(o_flags)) else $error("reg set skip");
    chk_skip_io_clr: assert property (tk && op == CSB_OP_SKIP_IO_CLEAR && !ib
        |=> o_skipping && !o_ready && $stable(o_flags)) else $error("io clear skip");
    chk_skip_io_set: assert property (tk && op == CSB_OP_SKIP_IO_SET && ib
        |=> o_skipping && !o_ready && $stable(o_flags)) else $error("io set skip");
    chk_branch_set_go: assert property (tk && op == CSB_OP_BRANCH_SET && fb
        |=> o_done && o_pc == $past(tgt)) else $error("set branch target");
    chk_branch_clr_go: assert property (tk && op == CSB_OP_BRANCH_CLEAR && !fb
        |=> o_pc == $past(tgt) && $stable(o_flags)) else $error("clear branch target");
    chk_skip_three_cyc: assert property (sk && i_instr.next_two_word
        |=> !o_done [*2] ##1 o_done && o_pc == $past(o_pc, 3) + 16'h0003) else $error("long skip");
    cover property (sk && i_instr.next_two_word);
    cover property (tk && op == CSB_OP_BRANCH_SET && fb);
    cover property (tk && op == CSB_OP_COMPARE_IMM);
endmodule
bind csb_exec csb_exec_assertions i_chk (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_valid(i_valid), .i_instr(i_instr), .i_reg_data(i_reg_data), .i_io_data(i_io_data),
    .o_ready(o_ready), .o_done(o_done), .o_pc(o_pc), .o_flags(o_flags),
    .o_skipping(o_skipping));
`default_nettype wire

/* File: sim/tb_compare_skip_branch_decode.sv */
// random self-checking bench for the compare/skip/branch execution unit
`timescale 1ns/1ns
`default_nettype none
module tb_compare_skip_branch_decode
    import csb_pkg::*;
;
    logic       i_clock = 1'b0;
    logic       i_nrst = 1'b0;
    logic       i_valid = 1'b0;
    csb_instr_t i_instr = '0;
    logic [7:0] i_reg_data = '0;
    logic [7:0] i_io_data = '0;
    logic       o_ready, o_done, o_skipping;
    logic [15:0] o_pc;
    logic [7:0] o_flags;
    logic [15:0] exp_pc = '0;
    logic [7:0] exp_flg = '0;
    int         n_errors = 0, total_checks = 0, cyc = 0;
    integer     seed = 32'h61d5;
    csb_exec i_dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_valid(i_valid), .i_instr(i_instr),
        .i_reg_data(i_reg_data), .i_io_data(i_io_data), .o_ready(o_ready), .o_done(o_done),
        .o_pc(o_pc), .o_flags(o_flags), .o_skipping(o_skipping));
    function automatic logic [7:0] cmpf(input logic [7:0] a, k, f);
        logic [7:0] r;
        logic [8:0] w;
        logic       v;
        r = a - k;
        // signed view in nine bits: overflow when the top two bits part
        w = {a[7], a} - {k[7], k};
        v = w[8] ^ w[7];
        return {f[7:6], a[3:0] < k[3:0], r[7] ^ v, v, r[7], r == 8'h00, a < k};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (n_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // valid stays high across runs, so back-to-back takes are exercised
    task automatic run(input logic [2:0] o, b, input logic [7:0] r, io, k,
                       input logic [6:0] off, input logic two);
        int   n;
        int   cy;
        logic hit;
        hit = o[2:1] inside {2'h1, 2'h2} && (o[1] ? r[b] : io[b]) == o[0];
        cy = hit ? (two ? 3 : 2) : 1;
        exp_pc = exp_pc + 16'(cy);
        if (o == 3'h1)
            exp_flg = cmpf(r, k, exp_flg);
        if (o[2:1] == 2'h3 && exp_flg[b] == !o[0])
            exp_pc = exp_pc + {{9{off[6]}}, off};
        i_valid = 1'b1;
        i_instr = '{csb_op_t'(o), 5'h00, 6'h00, b, k, off, two};
        i_reg_data = r;
        i_io_data = io;
        n = 0;
        do
        begin
            @(negedge i_clock);
            n++;
            // skip cycles hold off the next take
            check({15'h0000, o_skipping}, {15'h0000, n < cy});
            check({15'h0000, o_ready}, {15'h0000, n >= cy});
        end while (o_done !== 1'b1 && n < 6);
        check(16'(n), 16'(cy));
        check(o_pc, exp_pc);
        check({8'h00, o_flags}, {8'h00, exp_flg});
    endtask
    initial
    begin
        forever #50 i_clock = ~i_clock;
    end
    always @(posedge i_clock)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            summarize();
        end
    end
    initial
    begin
        repeat (8) @(posedge i_clock);
        @(negedge i_clock);
        i_nrst = 1'b1;
        @(negedge i_clock);
        run(3'h1, 3'h0, 8'h80, 8'h00, 8'h01, 7'h00, 1'b0);
        run(3'h1, 3'h0, 8'h5A, 8'h00, 8'h5A, 7'h00, 1'b0);
        run(3'h6, 3'h1, 8'h00, 8'h00, 8'h00, 7'h40, 1'b0);
        run(3'h7, 3'h1, 8'h00, 8'h00, 8'h00, 7'h3F, 1'b0);
        run(3'h2, 3'h7, 8'h7F, 8'h00, 8'h00, 7'h00, 1'b1);
        run(3'h5, 3'h5, 8'h00, 8'h20, 8'h00, 7'h00, 1'b0);
        // mid-run reset: pc and flags restart from their reset values
        i_valid = 1'b0;
        i_nrst = 1'b0;
        repeat (2) @(negedge i_clock);
        i_nrst = 1'b1;
        exp_pc = CSB_PC_RST;
        exp_flg = CSB_FLAGS_RST;
        @(negedge i_clock);
        run(3'h0, 3'h0, 8'h00, 8'h00, 8'h00, 7'h00, 1'b0);
        repeat (300) run(3'($random(seed)), 3'($random(seed)), 8'($random(seed)),
            8'($random(seed)), 8'($random(seed)), 7'($random(seed)), 1'($random(seed)));
        i_valid = 1'b0;
        summarize();
    end
endmodule
`default_nettype wire
